// ---- gpz_gauge_control.sv ----
// gpz_gauge_control: serial command receiver, command registers and two zeroing engines
module gpz_gauge_control
  import gpz_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // serial port pins
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  output logic             spi_miso_oe_out,
  // sigma-delta bits from the undriven coils
  input  wire logic        gauge0_bemf_in,
  input  wire logic        gauge1_bemf_in,
  // command registers
  output logic [11:0]      gauge0_position_value_out,
  output logic [11:0]      gauge1_position_value_out,
  output logic [7:0]       gauge0_velocity_limit_out,
  output logic [7:0]       gauge1_velocity_limit_out,
  // zeroing status and coil sequencing
  output logic             gauge0_zeroing_active_out,
  output logic             gauge1_zeroing_active_out,
  output logic             gauge0_stalled_out,
  output logic             gauge1_stalled_out,
  output logic             gauge0_step_done_out,
  output logic             gauge1_step_done_out,
  output logic [1:0]       gauge0_coil_step_out,
  output logic [1:0]       gauge1_coil_step_out
);

  gpz_top_state_type s;
  gpz_top_state_type next_s;

  logic        act0;
  logic        act1;
  logic        stall0;
  logic        stall1;
  logic [14:0] acc0;
  logic [14:0] acc1;

  gpz_zero_engine u_engine0 (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .start_in      (s.start[0]),
    .stop_in       (s.stop[0]),
    .uncond_in     (s.uncond),
    .dir_in        (s.dir),
    .cfg_in        (s.zero_cfg),
    .us_tick_in    (s.us_tick),
    .bemf_in       (s.bemf0_sync[1]),
    .active_out    (act0),
    .stalled_out   (stall0),
    .step_done_out (gauge0_step_done_out),
    .coil_step_out (gauge0_coil_step_out),
    .accum_out     (acc0)
  );

  gpz_zero_engine u_engine1 (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .start_in      (s.start[1]),
    .stop_in       (s.stop[1]),
    .uncond_in     (s.uncond),
    .dir_in        (s.dir),
    .cfg_in        (s.zero_cfg),
    .us_tick_in    (s.us_tick),
    .bemf_in       (s.bemf1_sync[1]),
    .active_out    (act1),
    .stalled_out   (stall1),
    .step_done_out (gauge1_step_done_out),
    .coil_step_out (gauge1_coil_step_out),
    .accum_out     (acc1)
  );

  always_comb
  begin
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic [15:0] status;
    logic [14:0] sel_acc;
    logic [2:0]  addr;
    logic [12:0] data;
    status   = '0;
    sck_rise = s.sck_sync[1] && !s.sck_last;
    sck_fall = !s.sck_sync[1] && s.sck_last;
    cs_fall  = !s.cs_n_sync[1] && s.cs_n_last;
    cs_rise  = s.cs_n_sync[1] && !s.cs_n_last;
    sel_acc  = s.zero_sel ? acc1 : acc0;
    if (s.accum_readout)
    begin
      status = {(s.zero_sel ? stall1 : stall0), sel_acc};
    end
    else
    begin
      status = {12'h000, act1, act0, stall1, stall0};
    end
    addr = s.shift[ADDR_HI:ADDR_LO];
    data = s.shift[DATA_W-1:0];

    next_s            = s;
    next_s.sck_sync   = {s.sck_sync[0], spi_sclk_in};
    next_s.cs_n_sync  = {s.cs_n_sync[0], spi_cs_n_in};
    next_s.mosi_sync  = {s.mosi_sync[0], spi_mosi_in};
    next_s.bemf0_sync = {s.bemf0_sync[0], gauge0_bemf_in};
    next_s.bemf1_sync = {s.bemf1_sync[0], gauge1_bemf_in};
    next_s.sck_last   = s.sck_sync[1];
    next_s.cs_n_last  = s.cs_n_sync[1];
    next_s.start      = 2'h0;
    next_s.stop       = 2'h0;

    // microsecond time base for step timing and integration
    if (s.us_div == US_DIV_LAST)
    begin
      next_s.us_div  = 5'h00;
      next_s.us_tick = 1'b1;
    end
    else
    begin
      next_s.us_div  = s.us_div + 5'h01;
      next_s.us_tick = 1'b0;
    end

    if (cs_fall)
    begin
      next_s.shift     = status;
      next_s.miso      = status[15];
      next_s.miso_oe   = 1'b1;
      next_s.bit_count = 4'h0;
      next_s.any_bits  = 1'b0;
    end
    else if (!s.cs_n_sync[1] && sck_rise)
    begin
      // bits past the first sixteen echo what came in, for daisy chains
      next_s.shift     = {s.shift[14:0], s.mosi_sync[1]};
      next_s.bit_count = s.bit_count + 4'h1;
      next_s.any_bits  = 1'b1;
    end
    else if (!s.cs_n_sync[1] && sck_fall)
    begin
      next_s.miso = s.shift[15];
    end
    else if (cs_rise)
    begin
      next_s.miso_oe = 1'b0;
      if (s.any_bits && s.bit_count == 4'h0)
      begin
        case (addr)
          ADDR_POWER_CONFIG:
          begin
            if (!data[PC_NULL_BIT] && !data[PC_ZERO6_BIT])
            begin
              next_s.accum_readout = data[PC_STATUS_BIT] && !data[PC_PTR_BIT];
            end
          end
          ADDR_VELOCITY:
          begin
            if (data[12:10] == 3'h0 && data[7:0] >= VEL_MIN && data[7:0] <= VEL_MAX)
            begin
              if (data[VEL_APPLY0_BIT])
              begin
                next_s.vel0 = data[7:0];
              end
              if (data[VEL_APPLY1_BIT])
              begin
                next_s.vel1 = data[7:0];
              end
            end
          end
          ADDR_GAUGE0_POS:
          begin
            if (!data[12])
            begin
              next_s.pos0 = data[11:0];
            end
          end
          ADDR_GAUGE1_POS:
          begin
            if (!data[12])
            begin
              next_s.pos1 = data[11:0];
            end
          end
          ADDR_ZERO_CMD:
          begin
            if (data[12:5] == 8'h00 && !data[ZC_ZERO3_BIT])
            begin
              next_s.zero_sel = data[ZC_SELECT_BIT];
              next_s.uncond   = data[ZC_UNCOND_BIT];
              next_s.dir      = data[ZC_DIR_BIT];
              if (data[ZC_ENABLE_BIT])
              begin
                next_s.start[data[ZC_SELECT_BIT]] = 1'b1;
              end
              else
              begin
                next_s.stop[data[ZC_SELECT_BIT]] = 1'b1;
              end
            end
          end
          ADDR_ZERO_CFG:
          begin
            next_s.zero_cfg = data;
          end
          default:
          begin
            next_s.zero_cfg = s.zero_cfg;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s           <= '0;
      s.sck_last  <= 1'b0;
      s.cs_n_sync <= 2'h3;
      s.cs_n_last <= 1'b1;
      s.pos0      <= POS_RESET;
      s.pos1      <= POS_RESET;
      s.vel0      <= VEL_RESET;
      s.vel1      <= VEL_RESET;
      s.zero_cfg  <= CFG_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign spi_miso_out              = s.miso;
  assign spi_miso_oe_out           = s.miso_oe;
  assign gauge0_position_value_out = s.pos0;
  assign gauge1_position_value_out = s.pos1;
  assign gauge0_velocity_limit_out = s.vel0;
  assign gauge1_velocity_limit_out = s.vel1;
  assign gauge0_zeroing_active_out = act0;
  assign gauge1_zeroing_active_out = act1;
  assign gauge0_stalled_out        = stall0;
  assign gauge1_stalled_out        = stall1;

endmodule

// ---- gpz_gauge_control_checker.sv ----
// gpz_gauge_control_checker: port-level properties of the gauge control block
module gpz_gauge_control_checker
  import gpz_pkg::*;
(
  // clock and reset
  input wire logic        clock_in,
  input wire logic        rst_in,
  // serial port
  input wire logic        spi_cs_n_in,
  input wire logic        spi_miso_oe_out,
  // command registers
  input wire logic [11:0] gauge0_position_value_out,
  input wire logic [11:0] gauge1_position_value_out,
  input wire logic [7:0]  gauge0_velocity_limit_out,
  input wire logic [7:0]  gauge1_velocity_limit_out,
  // zeroing status
  input wire logic        gauge0_zeroing_active_out,
  input wire logic        gauge1_zeroing_active_out,
  input wire logic        gauge0_stalled_out,
  input wire logic        gauge1_stalled_out,
  input wire logic        gauge0_step_done_out,
  input wire logic [1:0]  gauge0_coil_step_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  pos_hold_frame_a: assert property (!spi_cs_n_in [*6] |-> $stable(gauge0_position_value_out)
    && $stable(gauge1_position_value_out)) else $error("position changed inside a frame");
  vel_hold_frame_a: assert property (!spi_cs_n_in [*6] |-> $stable(gauge0_velocity_limit_out)
    && $stable(gauge1_velocity_limit_out)) else $error("velocity changed inside a frame");
  vel_range_a: assert property (gauge0_velocity_limit_out inside {[VEL_MIN:VEL_MAX]}
    && gauge1_velocity_limit_out inside {[VEL_MIN:VEL_MAX]}) else $error("velocity out of range");
  oe_drive_a: assert property (!spi_cs_n_in [*4] |-> spi_miso_oe_out)
    else $error("serial output not driven while selected");
  oe_release_a: assert property (spi_cs_n_in [*4] |-> !spi_miso_oe_out)
    else $error("serial output driven while deselected");
  step_pulse_a: assert property (gauge0_step_done_out |=> !gauge0_step_done_out)
    else $error("step end pulse longer than one cycle");
  step_when_active_a: assert property (gauge0_step_done_out |-> $past(gauge0_zeroing_active_out))
    else $error("step end without zeroing");
  stall_ends_a: assert property ($rose(gauge0_stalled_out) |-> !gauge0_zeroing_active_out)
    else $error("zeroing continues after stall");
  start_clears_a: assert property ($rose(gauge1_zeroing_active_out) |-> !gauge1_stalled_out)
    else $error("stall flag kept over a new start");
  coil_idle_a: assert property (!gauge0_zeroing_active_out && !$past(gauge0_zeroing_active_out)
    |-> $stable(gauge0_coil_step_out)) else $error("coil sequence moved while idle");

  step_seen_c: cover property (gauge0_step_done_out);
  stall_seen_c: cover property ($rose(gauge0_stalled_out));
  start_seen_c: cover property ($rose(gauge1_zeroing_active_out));
endmodule

// ---- gpz_host_model.sv ----
// gpz_host_model: serial host that frames command words on the device pins
module gpz_host_model
(
  // pacing clock
  input  wire logic clock_in,
  // serial pins
  output logic      spi_sclk_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out,
  input  wire logic spi_miso_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx_word;

  initial
  begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
    rx_word = 32'h0;
  end

  // n bits msb first, sclk idles low outside frames, 320 ns bit period
  task automatic send(input logic [31:0] w, input int n);
    int i;
    @(negedge clock_in);
    spi_cs_n_out = 1'b0;
    repeat (4) @(negedge clock_in);
    for (i = n - 1; i >= 0; i--)
    begin
      spi_mosi_out = w[i];
      repeat (4) @(negedge clock_in);
      spi_sclk_out = 1'b1;
      rx_word = {rx_word[30:0], spi_miso_in};
      repeat (4) @(negedge clock_in);
      spi_sclk_out = 1'b0;
    end
    repeat (4) @(negedge clock_in);
    spi_cs_n_out = 1'b1;
    // released data line must not keep its last value
    spi_mosi_out = ~spi_mosi_out;
    repeat (6) @(negedge clock_in);
  endtask
endmodule

// ---- gpz_pkg.sv ----
// gpz_pkg: constants, register map and state types for the gauge position and zeroing control
package gpz_pkg;

  // clock and time base
  localparam int unsigned CLOCK_HZ          = 25000000;
  localparam int unsigned TICK_HZ           = 1000000;
  localparam int unsigned US_CYCLES         = CLOCK_HZ / TICK_HZ;
  localparam logic [4:0]  US_DIV_LAST       = 5'(US_CYCLES - 1);
  localparam int unsigned STEP_INC_US       = 4096;
  localparam int unsigned BLANK_SHORT_US    = 512;
  localparam int unsigned BLANK_LONG_US     = 768;
  localparam int unsigned ZERO_CODE_ADD_US  = 2048;
  localparam int unsigned STEP_W            = 19;

  // word layout
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ADDR_HI   = 15;
  localparam int unsigned ADDR_LO   = 13;
  localparam int unsigned DATA_W    = 13;

  // register addresses
  localparam logic [2:0] ADDR_POWER_CONFIG = 3'h0;
  localparam logic [2:0] ADDR_VELOCITY     = 3'h1;
  localparam logic [2:0] ADDR_GAUGE0_POS   = 3'h2;
  localparam logic [2:0] ADDR_GAUGE1_POS   = 3'h3;
  localparam logic [2:0] ADDR_ZERO_CMD     = 3'h4;
  localparam logic [2:0] ADDR_ZERO_CFG     = 3'h5;

  // velocity_limit fields
  localparam int unsigned VEL_APPLY1_BIT = 9;
  localparam int unsigned VEL_APPLY0_BIT = 8;
  localparam logic [7:0]  VEL_MIN        = 8'h01;
  localparam logic [7:0]  VEL_MAX        = 8'he1;
  localparam logic [7:0]  VEL_RESET      = 8'he1;

  // power_config_command fields used for readout selection
  localparam int unsigned PC_NULL_BIT    = 12;
  localparam int unsigned PC_STATUS_BIT  = 11;
  localparam int unsigned PC_PTR_BIT     = 10;
  localparam int unsigned PC_ZERO6_BIT   = 6;

  // zeroing_command fields
  localparam int unsigned ZC_UNCOND_BIT  = 4;
  localparam int unsigned ZC_ZERO3_BIT   = 3;
  localparam int unsigned ZC_DIR_BIT     = 2;
  localparam int unsigned ZC_ENABLE_BIT  = 1;
  localparam int unsigned ZC_SELECT_BIT  = 0;

  // zeroing_configuration fields
  localparam int unsigned CFG_MULT_HI    = 12;
  localparam int unsigned CFG_MULT_LO    = 11;
  localparam int unsigned CFG_PRE_HI     = 10;
  localparam int unsigned CFG_PRE_LO     = 5;
  localparam int unsigned CFG_BLANK_BIT  = 4;
  localparam int unsigned CFG_INC_HI     = 3;
  localparam int unsigned CFG_INC_LO     = 0;
  localparam logic [12:0] CFG_RESET      = 13'h0003;

  // reset values of the remaining registers
  localparam logic [11:0] POS_RESET      = 12'h000;

  typedef enum logic [2:0] {
    GZ_IDLE  = 3'b001,
    GZ_BLANK = 3'b010,
    GZ_INTEG = 3'b100
  } gpz_phase_type;

  typedef struct packed {
    gpz_phase_type        phase;
    logic [STEP_W-1:0]    elapsed;
    logic [1:0]           coil_step;
    logic [14:0]          accum;
    logic                 active;
    logic                 stalled;
    logic                 uncond;
    logic                 dir;
    logic                 step_done;
  } gpz_engine_state_type;

  typedef struct packed {
    logic [1:0]  sck_sync;
    logic [1:0]  cs_n_sync;
    logic [1:0]  mosi_sync;
    logic [1:0]  bemf0_sync;
    logic [1:0]  bemf1_sync;
    logic        sck_last;
    logic        cs_n_last;
    logic [15:0] shift;
    logic [3:0]  bit_count;
    logic        any_bits;
    logic        miso;
    logic        miso_oe;
    logic [11:0] pos0;
    logic [11:0] pos1;
    logic [7:0]  vel0;
    logic [7:0]  vel1;
    logic [12:0] zero_cfg;
    logic        zero_sel;
    logic        accum_readout;
    logic [4:0]  us_div;
    logic        us_tick;
    logic [1:0]  start;
    logic [1:0]  stop;
    logic        uncond;
    logic        dir;
  } gpz_top_state_type;

endpackage

// ---- gpz_zero_engine.sv ----
// gpz_zero_engine: full-step zeroing sequencer and back-EMF stall integrator for one gauge
module gpz_zero_engine
  import gpz_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // commands
  input  wire logic        start_in,
  input  wire logic        stop_in,
  input  wire logic        uncond_in,
  input  wire logic        dir_in,
  input  wire logic [12:0] cfg_in,
  input  wire logic        us_tick_in,
  // synchronised sigma-delta bit from the undriven coil
  input  wire logic        bemf_in,
  // status
  output logic             active_out,
  output logic             stalled_out,
  output logic             step_done_out,
  output logic [1:0]       coil_step_out,
  output logic [14:0]      accum_out
);

  gpz_engine_state_type s;
  gpz_engine_state_type next_s;

  always_comb
  begin
    logic [STEP_W-1:0] blank_len;
    logic [STEP_W-1:0] base_len;
    logic [STEP_W-1:0] step_len;
    logic [STEP_W-1:0] elapsed_inc;
    logic [14:0]       preload;
    logic [14:0]       acc_new;
    logic [1:0]        step_adv;
    step_len  = '0;
    blank_len = cfg_in[CFG_BLANK_BIT] ? STEP_W'(BLANK_LONG_US) : STEP_W'(BLANK_SHORT_US);
    base_len  = STEP_W'(cfg_in[CFG_INC_HI:CFG_INC_LO]) * STEP_W'(STEP_INC_US);
    base_len  = base_len << cfg_in[CFG_MULT_HI:CFG_MULT_LO];
    if (cfg_in[CFG_INC_HI:CFG_INC_LO] == 4'h0)
    begin
      step_len = blank_len + STEP_W'(ZERO_CODE_ADD_US);
    end
    else
    begin
      step_len = base_len + blank_len;
    end
    // start value is minus sixteen times preload minus one, i.e. the complement
    preload     = ~{5'h00, cfg_in[CFG_PRE_HI:CFG_PRE_LO], 4'h0};
    elapsed_inc = s.elapsed + STEP_W'(1);
    step_adv    = s.dir ? s.coil_step + 2'h1 : s.coil_step - 2'h1;
    acc_new     = s.accum;
    next_s           = s;
    next_s.step_done = 1'b0;
    if (start_in)
    begin
      next_s.phase     = GZ_BLANK;
      next_s.active    = 1'b1;
      next_s.elapsed   = '0;
      next_s.accum     = preload;
      next_s.stalled   = 1'b0;
      next_s.uncond    = uncond_in;
      next_s.dir       = dir_in;
      next_s.coil_step = dir_in ? s.coil_step + 2'h1 : s.coil_step - 2'h1;
    end
    else if (stop_in)
    begin
      next_s.phase  = GZ_IDLE;
      next_s.active = 1'b0;
    end
    else
    begin
      case (s.phase)
        GZ_IDLE:
        begin
          next_s.active = 1'b0;
        end
        GZ_BLANK, GZ_INTEG:
        begin
          if (us_tick_in)
          begin
            next_s.elapsed = elapsed_inc;
            if (s.phase == GZ_INTEG)
            begin
              // saturating sigma-delta integration of the undriven coil
              if (bemf_in && s.accum != 15'h3fff)
              begin
                acc_new = s.accum + 15'h0001;
              end
              else if (!bemf_in && s.accum != 15'h4000)
              begin
                acc_new = s.accum - 15'h0001;
              end
              next_s.accum = acc_new;
            end
            if (elapsed_inc >= blank_len)
            begin
              next_s.phase = GZ_INTEG;
            end
            if (elapsed_inc >= step_len)
            begin
              next_s.step_done = 1'b1;
              if (acc_new[14] && !s.uncond)
              begin
                next_s.phase   = GZ_IDLE;
                next_s.active  = 1'b0;
                next_s.stalled = 1'b1;
                next_s.accum   = acc_new;
              end
              else
              begin
                next_s.phase     = GZ_BLANK;
                next_s.elapsed   = '0;
                next_s.accum     = preload;
                next_s.coil_step = step_adv;
              end
            end
          end
        end
        default:
        begin
          next_s.phase  = GZ_IDLE;
          next_s.active = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s           <= '0;
      s.phase     <= GZ_IDLE;
      s.accum     <= 15'h7fff;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign active_out    = s.active;
  assign stalled_out   = s.stalled;
  assign step_done_out = s.step_done;
  assign coil_step_out = s.coil_step;
  assign accum_out     = s.accum;

endmodule

// ---- test_gpz_gauge_control.sv ----
// test_gpz_gauge_control: register writes, refusals and one zeroing step
module test_gpz_gauge_control
  import gpz_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic sclk, cs_n, mosi, miso_o, miso_oe, b0 = 1'b0, b1 = 1'b1;
  logic a0, a1, s0, s1, d0, d1;
  logic [11:0] p0, p1;
  logic [7:0] v0, v1;
  logic [1:0] c0, c1;
  int bad_count = 0;
  int checked = 0;
  wire miso_w = miso_oe ? miso_o : 1'bz;

  always #20 clock_in = ~clock_in;

  gpz_host_model host_u (.clock_in(clock_in), .spi_sclk_out(sclk), .spi_cs_n_out(cs_n),
    .spi_mosi_out(mosi), .spi_miso_in(miso_w));

  gpz_gauge_control dut_u (.clock_in(clock_in), .rst_in(rst_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso_o),
    .spi_miso_oe_out(miso_oe), .gauge0_bemf_in(b0), .gauge1_bemf_in(b1),
    .gauge0_position_value_out(p0), .gauge1_position_value_out(p1),
    .gauge0_velocity_limit_out(v0), .gauge1_velocity_limit_out(v1),
    .gauge0_zeroing_active_out(a0), .gauge1_zeroing_active_out(a1),
    .gauge0_stalled_out(s0), .gauge1_stalled_out(s1),
    .gauge0_step_done_out(d0), .gauge1_step_done_out(d1),
    .gauge0_coil_step_out(c0), .gauge1_coil_step_out(c1));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] w);
    host_u.send({16'h0000, w}, 16);
    repeat (8) @(negedge clock_in);
  endtask

  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_position;
    wr({ADDR_GAUGE0_POS, 13'h0fff});
    wr({ADDR_GAUGE1_POS, 13'h0123});
    chk(p0, 16'h0fff);
    chk(p1, 16'h0123);
    wr({ADDR_GAUGE0_POS, 13'h1555});
    chk(p0, 16'h0fff);
    host_u.send({16'h0000, ADDR_GAUGE1_POS, 13'h0aaa}, 8);
    chk(p1, 16'h0123);
    host_u.send({ADDR_GAUGE0_POS, 13'h0111, ADDR_GAUGE1_POS, 13'h0222}, 32);
    chk(p0, 16'h0fff);
    chk(p1, 16'h0222);
  endtask

  task automatic t_velocity;
    chk(v0, 16'h00e1);
    wr({ADDR_VELOCITY, 13'h0110});
    chk(v0, 16'h0010);
    chk(v1, 16'h00e1);
    wr({ADDR_VELOCITY, 13'h0201});
    chk(v0, 16'h0010);
    chk(v1, 16'h0001);
    wr({ADDR_VELOCITY, 13'h03e1});
    chk(v0, 16'h00e1);
    chk(v1, 16'h00e1);
    wr({ADDR_VELOCITY, 13'h0720});
    wr({ADDR_VELOCITY, 13'h0300});
    chk(v0, 16'h00e1);
    chk(v1, 16'h00e1);
  endtask

  task automatic t_start_stop;
    wr({ADDR_ZERO_CMD, 13'h000b});
    chk(a1, 16'h0000);
    wr({ADDR_ZERO_CMD, 13'h0003});
    chk(a1, 16'h0001);
    chk(a0, 16'h0000);
    chk(c1, 16'h0003);
    wr({ADDR_ZERO_CMD, 13'h0001});
    chk(a1, 16'h0000);
    chk(s1, 16'h0000);
  endtask

  task automatic t_stall;
    int n;
    int n1;
    n = 0;
    n1 = 0;
    wr({ADDR_ZERO_CFG, 13'h0000});
    wr({ADDR_ZERO_CMD, 13'h0002});
    chk(a0, 16'h0001);
    while (d0 !== 1'b1 && n < 70000)
    begin
      @(negedge clock_in);
      n++;
      if (d1 !== 1'b0)
      begin
        n1++;
      end
    end
    // 512 us blanking plus 2048 us at 25 cycles per us
    chk(16'(n > 63900 && n < 64100), 16'h0001);
    repeat (2) @(negedge clock_in);
    chk(s0, 16'h0001);
    chk(a0, 16'h0000);
    chk(c0, 16'h0003);
    chk(16'(n1), 16'h0000);
  endtask

  // status readout, preload end value and a mid-run reset
  task automatic t_readout;
    host_u.send({16'h0000, 16'h1000}, 16);
    chk(host_u.rx_word[15:0], 16'h0001);
    wr({ADDR_POWER_CONFIG, 13'h0800});
    // stalled flag on top, then -1 less 2048 integration counts
    host_u.send({16'h0000, 16'h1000}, 16);
    chk(host_u.rx_word[15:0], 16'hf7ff);
    wr({ADDR_ZERO_CFG, 13'h07e0});
    wr({ADDR_ZERO_CMD, 13'h0002});
    wr({ADDR_ZERO_CMD, 13'h0000});
    host_u.send({16'h0000, 16'h1000}, 16);
    chk(host_u.rx_word[15:0], 16'h7c0f);
    @(negedge clock_in);
    rst_in = 1'b1;
    repeat (3) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk(p0, 16'h0000);
    chk(p1, 16'h0000);
    wr({ADDR_POWER_CONFIG, 13'h0800});
    host_u.send({16'h0000, 16'h1000}, 16);
    chk(host_u.rx_word[15:0], 16'h7fff);
  endtask

  initial
  begin
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk(p0, 16'h0000);
    t_position();
    t_velocity();
    t_start_stop();
    t_stall();
    t_readout();
    wrap_up();
  end

  initial
  begin
    repeat (90000) @(posedge clock_in);
    bad_count++;
    wrap_up();
  end
endmodule

bind gpz_gauge_control gpz_gauge_control_checker chk_u (.clock_in(clock_in), .rst_in(rst_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_out(spi_miso_oe_out),
  .gauge0_position_value_out(gauge0_position_value_out),
  .gauge1_position_value_out(gauge1_position_value_out),
  .gauge0_velocity_limit_out(gauge0_velocity_limit_out),
  .gauge1_velocity_limit_out(gauge1_velocity_limit_out),
  .gauge0_zeroing_active_out(gauge0_zeroing_active_out),
  .gauge1_zeroing_active_out(gauge1_zeroing_active_out),
  .gauge0_stalled_out(gauge0_stalled_out), .gauge1_stalled_out(gauge1_stalled_out),
  .gauge0_step_done_out(gauge0_step_done_out), .gauge0_coil_step_out(gauge0_coil_step_out));
